// File: scir_pkg.sv
// Notes on behaviour
// - Writing one to bit 7 of register soft_reset_and_wire_mode resets the device; bit self-clears.
// - Bit 4 of soft_reset_and_wire_mode disables three-wire readback when one; resets to zero.
// - Three-wire and four-wire readback may run at the same time.
// - Bit 0 of 0x002 sets device_sleep; serial port and registers stay active; resets zero; 7:1 reserved.
// - Register 0x003 returns the 8-bit device type code; writes ignored.
// - Product code: high byte at 0x004, low byte at 0x005, read only.
// - Register 0x006 returns the 8-bit read-only silicon revision code.
// - Vendor code: high byte at 0x00C, low byte at 0x00D, read only.
// - Per-output field indices: even 0 to 12, odd 1 to 13, odd is even+1.
// - Addresses are 15 bits wide; each register holds data bits 7 down to 0.
package scir_pkg;
    localparam int ADDR_W     = 15;
    localparam int DATA_W     = 8;
    localparam int FRAME_BITS = 24;
    localparam int HDR_BITS   = 16;
    localparam int CNT_W      = 5;

    localparam logic [ADDR_W-1:0] OFS_SYS_CTRL    = 15'h0000;
    localparam logic [ADDR_W-1:0] OFS_SLEEP       = 15'h0002;
    localparam logic [ADDR_W-1:0] OFS_DEV_TYPE    = 15'h0003;
    localparam logic [ADDR_W-1:0] OFS_PROD_HIGH   = 15'h0004;
    localparam logic [ADDR_W-1:0] OFS_PROD_LOW    = 15'h0005;
    localparam logic [ADDR_W-1:0] OFS_REVISION    = 15'h0006;
    localparam logic [ADDR_W-1:0] OFS_VENDOR_HIGH = 15'h000C;
    localparam logic [ADDR_W-1:0] OFS_VENDOR_LOW  = 15'h000D;

    localparam int BIT_SOFT_RESET  = 7;
    localparam int BIT_THREE_WIRE  = 4;
    localparam int BIT_SLEEP       = 0;

    localparam logic RST_THREE_WIRE_DIS = 1'b0;
    localparam logic RST_SLEEP          = 1'b0;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

    // Per-output replication: odd index is even index plus one
    function automatic logic [3:0] odd_index(input logic [3:0] even_idx);
        odd_index = even_idx + 4'h1;
    endfunction
endpackage

// File: scir_reg_if.sv
`timescale 1ns/1ps
interface scir_reg_if;
    logic                            wr_en;
    logic [scir_pkg::ADDR_W-1:0]     addr;
    logic [scir_pkg::DATA_W-1:0]     wdata;
    logic [scir_pkg::DATA_W-1:0]     rdata;
    logic                            three_wire_dis;

    modport bank (
        input  wr_en,
        input  addr,
        input  wdata,
        output rdata,
        output three_wire_dis
    );
    modport engine (
        output wr_en,
        output addr,
        output wdata,
        input  rdata,
        input  three_wire_dis
    );
endinterface

// File: scir_regfile.sv
`timescale 1ns/1ps
module scir_regfile #(
    parameter logic [7:0]  DEVICE_TYPE_CODE      = 8'h5A,
    parameter logic [15:0] PRODUCT_CODE          = 16'hA5C3,
    parameter logic [7:0]  SILICON_REVISION_CODE = 8'h11,
    parameter logic [15:0] VENDOR_CODE           = 16'h3C96
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Register access
    scir_reg_if.bank  rif,
    // Device controls
    output logic      device_sleep,
    output logic      device_reset
);
    logic three_wire_dis;
    logic next_three_wire_dis;
    logic next_device_sleep;
    logic next_device_reset;

    // Read decode; unmapped and reserved bits read zero
    function automatic logic [7:0] read_decode(input logic [14:0] a,
                                               input logic        twd,
                                               input logic        slp);
        logic [7:0] d;
        d = scir_pkg::ZERO_BYTE;
        case (a)
            scir_pkg::OFS_SYS_CTRL:    d[scir_pkg::BIT_THREE_WIRE] = twd;
            scir_pkg::OFS_SLEEP:       d[scir_pkg::BIT_SLEEP] = slp;
            scir_pkg::OFS_DEV_TYPE:    d = DEVICE_TYPE_CODE;
            scir_pkg::OFS_PROD_HIGH:   d = PRODUCT_CODE[15:8];
            scir_pkg::OFS_PROD_LOW:    d = PRODUCT_CODE[7:0];
            scir_pkg::OFS_REVISION:    d = SILICON_REVISION_CODE;
            scir_pkg::OFS_VENDOR_HIGH: d = VENDOR_CODE[15:8];
            scir_pkg::OFS_VENDOR_LOW:  d = VENDOR_CODE[7:0];
            default:                   d = scir_pkg::ZERO_BYTE;
        endcase
        read_decode = d;
    endfunction

    always_comb begin
        next_three_wire_dis = three_wire_dis;
        next_device_sleep   = device_sleep;
        next_device_reset   = 1'b0;
        if (device_reset) begin
            // Soft reset returns the bank to power-on values
            next_three_wire_dis = scir_pkg::RST_THREE_WIRE_DIS;
            next_device_sleep   = scir_pkg::RST_SLEEP;
        end else if (rif.wr_en) begin
            if (rif.addr == scir_pkg::OFS_SYS_CTRL) begin
                next_device_reset   = rif.wdata[scir_pkg::BIT_SOFT_RESET];
                next_three_wire_dis = rif.wdata[scir_pkg::BIT_THREE_WIRE];
            end else if (rif.addr == scir_pkg::OFS_SLEEP) begin
                next_device_sleep = rif.wdata[scir_pkg::BIT_SLEEP];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            three_wire_dis <= scir_pkg::RST_THREE_WIRE_DIS;
            device_sleep   <= scir_pkg::RST_SLEEP;
            device_reset   <= 1'b0;
        end else begin
            three_wire_dis <= next_three_wire_dis;
            device_sleep   <= next_device_sleep;
            device_reset   <= next_device_reset;
        end
    end

    assign rif.three_wire_dis = three_wire_dis;
    assign rif.rdata          = read_decode(rif.addr, three_wire_dis, device_sleep);
endmodule

// File: scir_top.sv
`timescale 1ns/1ps
module scir_top #(
    parameter logic [7:0]  DEVICE_TYPE_CODE      = 8'h5A,   // Arbitrary value
    parameter logic [15:0] PRODUCT_CODE          = 16'hA5C3, // Arbitrary value
    parameter logic [7:0]  SILICON_REVISION_CODE = 8'h11,   // Arbitrary value
    parameter logic [15:0] VENDOR_CODE           = 16'h3C96  // Arbitrary value
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Serial pins
    input  wire logic scs_n,
    input  wire logic sck,
    input  wire logic sdio_in,
    output logic      sdio_out,
    output logic      sdio_oe,
    // Four-wire readback pin
    input  wire logic readback_pin_select,
    output logic      readback_pin_out,
    output logic      readback_pin_oe,
    // Device controls
    output logic      three_wire_readback_disable,
    output logic      device_sleep,
    output logic      device_reset
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HEADER,
        ST_WRITE,
        ST_READ,
        ST_DONE
    } scir_state_t;

    scir_reg_if rif ();

    // Pin synchronisers
    logic scs_n_s1;
    logic scs_n_s2;
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic sdio_s1;
    logic sdio_s2;

    scir_state_t                   state;
    scir_state_t                   next_state;
    logic [scir_pkg::CNT_W-1:0]    bit_cnt;
    logic [scir_pkg::CNT_W-1:0]    next_bit_cnt;
    logic [scir_pkg::FRAME_BITS-1:0] in_sr;
    logic [scir_pkg::FRAME_BITS-1:0] next_in_sr;
    logic [scir_pkg::DATA_W-1:0]   out_sr;
    logic [scir_pkg::DATA_W-1:0]   next_out_sr;
    logic                          loaded;
    logic                          next_loaded;
    logic [scir_pkg::ADDR_W-1:0]   addr;
    logic [scir_pkg::ADDR_W-1:0]   next_addr;
    logic [scir_pkg::DATA_W-1:0]   wdata;
    logic [scir_pkg::DATA_W-1:0]   next_wdata;
    logic                          wr_en;
    logic                          next_wr_en;
    logic                          sck_rise;
    logic                          sck_fall;
    logic                          cs_end;
    logic                          driving;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scs_n_s1 <= 1'b1;
            scs_n_s2 <= 1'b1;
            sck_s1   <= 1'b0;
            sck_s2   <= 1'b0;
            sck_s3   <= 1'b0;
            sdio_s1  <= 1'b0;
            sdio_s2  <= 1'b0;
        end else begin
            scs_n_s1 <= scs_n;
            scs_n_s2 <= scs_n_s1;
            sck_s1   <= sck;
            sck_s2   <= sck_s1;
            sck_s3   <= sck_s2;
            sdio_s1  <= sdio_in;
            sdio_s2  <= sdio_s1;
        end
    end

    assign sck_rise = sck_s2 & ~sck_s3;
    assign sck_fall = ~sck_s2 & sck_s3;
    assign cs_end   = scs_n_s2;

    // Frame: read flag, 15-bit address, 8 data bits, MSB first
    always_comb begin
        next_state   = state;
        next_bit_cnt = bit_cnt;
        next_in_sr   = in_sr;
        next_out_sr  = out_sr;
        next_loaded  = loaded;
        next_addr    = addr;
        next_wdata   = wdata;
        next_wr_en   = 1'b0;
        case (state)
            ST_IDLE: begin
                next_bit_cnt = '0;
                next_loaded  = 1'b0;
                if (!scs_n_s2) begin
                    next_state = ST_HEADER;
                end
            end
            ST_HEADER: begin
                if (cs_end) begin
                    next_state = ST_IDLE;
                end else if (sck_rise) begin
                    next_in_sr   = {in_sr[scir_pkg::FRAME_BITS-2:0], sdio_s2};
                    next_bit_cnt = bit_cnt + 1'b1;
                    if (bit_cnt == 5'(scir_pkg::HDR_BITS - 1)) begin
                        next_addr  = {in_sr[scir_pkg::ADDR_W-2:0], sdio_s2};
                        next_state = in_sr[scir_pkg::ADDR_W-1] ? ST_READ : ST_WRITE;
                    end
                end
            end
            ST_WRITE: begin
                if (cs_end) begin
                    next_state = ST_IDLE;
                end else if (sck_rise) begin
                    next_in_sr   = {in_sr[scir_pkg::FRAME_BITS-2:0], sdio_s2};
                    next_bit_cnt = bit_cnt + 1'b1;
                    if (bit_cnt == 5'(scir_pkg::FRAME_BITS - 1)) begin
                        next_wdata = {in_sr[scir_pkg::DATA_W-2:0], sdio_s2};
                        next_wr_en = 1'b1;
                        next_state = ST_DONE;
                    end
                end
            end
            ST_READ: begin
                if (cs_end) begin
                    next_state = ST_IDLE;
                end else begin
                    if (sck_fall) begin
                        if (!loaded) begin
                            next_out_sr = rif.rdata;
                            next_loaded = 1'b1;
                        end else begin
                            next_out_sr = {out_sr[scir_pkg::DATA_W-2:0], 1'b0};
                        end
                    end
                    if (sck_rise) begin
                        next_bit_cnt = bit_cnt + 1'b1;
                        if (bit_cnt == 5'(scir_pkg::FRAME_BITS - 1)) begin
                            next_state = ST_DONE;
                        end
                    end
                end
            end
            ST_DONE: begin
                if (cs_end) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state   <= ST_IDLE;
            bit_cnt <= '0;
            in_sr   <= '0;
            out_sr  <= scir_pkg::ZERO_BYTE;
            loaded  <= 1'b0;
            addr    <= '0;
            wdata   <= scir_pkg::ZERO_BYTE;
            wr_en   <= 1'b0;
        end else begin
            state   <= next_state;
            bit_cnt <= next_bit_cnt;
            in_sr   <= next_in_sr;
            out_sr  <= next_out_sr;
            loaded  <= next_loaded;
            addr    <= next_addr;
            wdata   <= next_wdata;
            wr_en   <= next_wr_en;
        end
    end

    assign rif.wr_en = wr_en;
    assign rif.addr  = addr;
    assign rif.wdata = wdata;

    scir_regfile #(
        .DEVICE_TYPE_CODE      (DEVICE_TYPE_CODE),
        .PRODUCT_CODE          (PRODUCT_CODE),
        .SILICON_REVISION_CODE (SILICON_REVISION_CODE),
        .VENDOR_CODE           (VENDOR_CODE)
    ) u_regfile (
        .clk          (clk),
        .rst_n        (rst_n),
        .rif          (rif.bank),
        .device_sleep (device_sleep),
        .device_reset (device_reset)
    );

    // Readback drives both paths independently
    assign driving          = (state == ST_READ) && loaded;
    assign sdio_out         = out_sr[scir_pkg::DATA_W-1];
    assign sdio_oe          = driving && !rif.three_wire_dis;
    assign readback_pin_out = out_sr[scir_pkg::DATA_W-1];
    assign readback_pin_oe  = driving && readback_pin_select;

    assign three_wire_readback_disable = rif.three_wire_dis;
endmodule

// File: scir_top_monitor.sv
`timescale 1ns/1ps
module scir_top_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Serial pins
    input wire logic scs_n,
    input wire logic sck,
    input wire logic sdio_in,
    input wire logic sdio_out,
    input wire logic sdio_oe,
    // Readback pin
    input wire logic readback_pin_select,
    input wire logic readback_pin_out,
    input wire logic readback_pin_oe,
    // Device controls
    input wire logic three_wire_readback_disable,
    input wire logic device_sleep,
    input wire logic device_reset
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_reset_pulse_single: assert property (device_reset |=> !device_reset)
        else $error("soft reset pulse longer than one cycle");
    a_reset_clears_bits: assert property (device_reset |=> ##1
        (!device_sleep && !three_wire_readback_disable))
        else $error("soft reset left control bits set");
    a_reset_clean_start: assert property ($rose(rst_n) |->
        !device_sleep && !device_reset && !three_wire_readback_disable && !sdio_oe)
        else $error("outputs not clear after reset");
    a_three_wire_off: assert property (three_wire_readback_disable |-> !sdio_oe)
        else $error("data line driven while three-wire disabled");
    a_pin_needs_select: assert property (readback_pin_oe |-> readback_pin_select)
        else $error("readback pin driven without selection");
    a_both_paths_on: assert property (sdio_oe && readback_pin_select |-> readback_pin_oe)
        else $error("four-wire path missing during three-wire read");
    a_same_bit_out: assert property (readback_pin_oe |-> readback_pin_out == sdio_out)
        else $error("readback paths disagree");
    a_idle_no_drive: assert property (scs_n [*5] |-> !sdio_oe && !readback_pin_oe)
        else $error("pins driven outside a frame");
    a_sleep_held_idle: assert property (scs_n [*5] |=> $stable(device_sleep))
        else $error("power-down changed outside a frame");
endmodule

bind scir_top scir_top_monitor u_mon (
    .clk(clk), .rst_n(rst_n), .scs_n(scs_n), .sck(sck), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .readback_pin_select(readback_pin_select),
    .readback_pin_out(readback_pin_out), .readback_pin_oe(readback_pin_oe),
    .three_wire_readback_disable(three_wire_readback_disable),
    .device_sleep(device_sleep), .device_reset(device_reset)
);

// File: scir_host.sv
`timescale 1ns/1ps
module scir_host (
    // Clock
    input  wire logic clk,
    // Serial pins
    output logic      scs_n,
    output logic      sck,
    output logic      sdio_in,
    input  wire logic sdio_out,
    input  wire logic sdio_oe,
    // Readback pin
    input  wire logic readback_pin_out,
    input  wire logic readback_pin_oe
);
    logic host_bit;
    logic host_en;

    // Shared data line: device when enabled, else host, else a changed level
    always_comb sdio_in = sdio_oe ? sdio_out : (host_en ? host_bit : ~host_bit);

    initial begin
        scs_n = 1'b1;
        sck = 1'b0;
        host_bit = 1'b0;
        host_en = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One frame: read flag, address, data, MSB first; levels held six cycles
    task automatic xfer(input logic rd, input logic [14:0] addr, input logic [7:0] wd,
                        input logic four, output logic [7:0] q);
        logic [23:0] frm;
        frm = {rd, addr, wd};
        q = 8'h00;
        scs_n = 1'b0;
        wait_clk(6);
        for (int i = 23; i >= 0; i--) begin
            host_en = !(rd && i < 8);
            host_bit = frm[i];
            wait_clk(6);
            sck = 1'b1;
            if (i < 8)
                q[i] = four ? (readback_pin_oe ? readback_pin_out : ~host_bit) : sdio_in;
            wait_clk(6);
            sck = 1'b0;
        end
        host_en = 1'b0;
        wait_clk(6);
        scs_n = 1'b1;
        wait_clk(8);
    endtask
endmodule

// File: scir_top_test.sv
`timescale 1ns/1ps
module scir_top_test;
    localparam logic [7:0]  DEV_TYPE = 8'h3E;    // Arbitrary value
    localparam logic [15:0] PROD     = 16'h7B29; // Arbitrary value
    localparam logic [7:0]  REV      = 8'h42;    // Arbitrary value
    localparam logic [15:0] VENDOR   = 16'hC618; // Arbitrary value
    logic       clk;
    logic       rst_n;
    logic       readback_pin_select;
    logic       scs_n, sck, sdio_in, sdio_out, sdio_oe;
    logic       readback_pin_out, readback_pin_oe;
    logic       three_wire_readback_disable, device_sleep, device_reset;
    logic [7:0] q;
    int         n_mismatch;
    int         tests_run;
    int         pulses;

    scir_top #(.DEVICE_TYPE_CODE(DEV_TYPE), .PRODUCT_CODE(PROD),
               .SILICON_REVISION_CODE(REV), .VENDOR_CODE(VENDOR)) u_dut (
        .clk(clk), .rst_n(rst_n), .scs_n(scs_n), .sck(sck), .sdio_in(sdio_in),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe), .readback_pin_select(readback_pin_select),
        .readback_pin_out(readback_pin_out), .readback_pin_oe(readback_pin_oe),
        .three_wire_readback_disable(three_wire_readback_disable),
        .device_sleep(device_sleep), .device_reset(device_reset));
    scir_host u_host (
        .clk(clk), .scs_n(scs_n), .sck(sck), .sdio_in(sdio_in), .sdio_out(sdio_out),
        .sdio_oe(sdio_oe), .readback_pin_out(readback_pin_out),
        .readback_pin_oe(readback_pin_oe));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (device_reset === 1'b1) pulses++;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        u_host.xfer(1'b0, a, d, 1'b0, q);
    endtask
    task automatic rd(input logic [14:0] a, input logic four, input logic [7:0] exp);
        u_host.xfer(1'b1, a, 8'h00, four, q);
        check(q, exp);
    endtask
    task automatic ctrl(input logic [7:0] exp);
        check({6'h00, three_wire_readback_disable, device_sleep}, exp);
    endtask

    task automatic t_reset_values();
        ctrl(8'h00);
        rd(scir_pkg::OFS_SYS_CTRL, 1'b0, 8'h00);
        rd(scir_pkg::OFS_SLEEP, 1'b0, 8'h00);
    endtask
    task automatic t_id_codes();
        logic [14:0] a[6];
        logic [7:0]  e[6];
        a = '{scir_pkg::OFS_DEV_TYPE, scir_pkg::OFS_PROD_HIGH, scir_pkg::OFS_PROD_LOW,
              scir_pkg::OFS_REVISION, scir_pkg::OFS_VENDOR_HIGH, scir_pkg::OFS_VENDOR_LOW};
        e = '{DEV_TYPE, PROD[15:8], PROD[7:0], REV, VENDOR[15:8], VENDOR[7:0]};
        for (int i = 0; i < 6; i++) begin
            wr(a[i], ~e[i]);
            rd(a[i], 1'b0, e[i]);
        end
        wr(15'h7FFF, 8'hFF);
        rd(15'h7FFF, 1'b0, 8'h00);
        check({4'h0, scir_pkg::odd_index(4'hC)}, 8'h0D);
        check({4'h0, scir_pkg::odd_index(4'h0)}, 8'h01);
    endtask
    task automatic t_sleep();
        wr(scir_pkg::OFS_SLEEP, 8'hFF);
        ctrl(8'h01);
        rd(scir_pkg::OFS_SLEEP, 1'b0, 8'h01);
        wr(scir_pkg::OFS_SLEEP, 8'h00);
        ctrl(8'h00);
    endtask
    task automatic t_wire_modes();
        wr(scir_pkg::OFS_SYS_CTRL, 8'h7F);
        ctrl(8'h02);
        @(posedge clk);
        #1 readback_pin_select = 1'b1;
        rd(scir_pkg::OFS_SYS_CTRL, 1'b1, 8'h10);
        wr(scir_pkg::OFS_SYS_CTRL, 8'h00);
        rd(scir_pkg::OFS_DEV_TYPE, 1'b0, DEV_TYPE);
        rd(scir_pkg::OFS_DEV_TYPE, 1'b1, DEV_TYPE);
    endtask
    task automatic t_soft_reset();
        wr(scir_pkg::OFS_SLEEP, 8'h01);
        wr(scir_pkg::OFS_SYS_CTRL, 8'h10);
        ctrl(8'h03);
        pulses = 0;
        wr(scir_pkg::OFS_SYS_CTRL, 8'h90);
        check(pulses[7:0], 8'h01);
        ctrl(8'h00);
        rd(scir_pkg::OFS_SYS_CTRL, 1'b0, 8'h00);
    endtask
    task automatic t_power_on_reset();
        wr(scir_pkg::OFS_SLEEP, 8'h01);
        wr(scir_pkg::OFS_SYS_CTRL, 8'h10);
        ctrl(8'h03);
        rst_n = 1'b0;
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        ctrl(8'h00);
        rd(scir_pkg::OFS_SYS_CTRL, 1'b0, 8'h00);
        rd(scir_pkg::OFS_SLEEP, 1'b0, 8'h00);
    endtask

    initial begin
        rst_n = 1'b0;
        readback_pin_select = 1'b0;
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        t_reset_values();
        t_id_codes();
        t_sleep();
        t_wire_modes();
        t_soft_reset();
        t_power_on_reset();
        test_done();
    end
    initial begin
        repeat (50000) @(posedge clk);
        n_mismatch++;
        test_done();
    end
endmodule
